// [src/srd_rx_top.sv]
// Receive deserializer, 8b/10b decoder, link sync machine and AHB status
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Overview of operation
// - Each received word leaves as 16 registered bits, valid at word clock rise.
// - Serial-to-parallel latency is fixed once linked, between 76 and 107 bit times.
// - Link bit rate must stay within 200 PPM of the local bit clock.
// - The 20-bit word splits into two 10-bit halves, each decoded separately.
// - First serial bit of a word lands in bit 0 of the output.
// - Seven-bit comma patterns realign the stream to character boundaries.
// - Realignment stops after an aligned comma once linked, resumes on sync loss.
// - Flags: idle 00, carrier extend 01, data 10, error propagation 11.
// - Error propagation gives FEFE with both flags; invalid code raises both flags.
// - Idle outputs K28.5 then D5.6 or D16.2 with both flags low.
// - Loss of signal drives valid, error and all data bits high.
// - Enable low tri-states serial outputs, data bus and error flag.
// - In power-down the valid pin follows the signal detector.
// - Reset puts the sync machine into acquisition, looking for idle.
// - Three consecutive idle or carrier extend words in acquisition enter sync.
// - Data or error propagation in acquisition enters sync at once.
// - Invalid code in sync is flagged and moves to check.
// - Four consecutive valid codes in check return to sync.
// - Three invalid codes in check drop back to acquisition.
// ************************************************************
module srd_rx_top #(
  parameter int LAT_WORDS = srd_pkg::SRD_LAT_WORDS
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire srd_pkg::srd_ahb_req_t ahb_req,
  output var  srd_pkg::srd_ahb_rsp_t ahb_rsp,
  input  wire logic                  link_bit_clk,
  input  wire logic                  serial_in_pos,
  input  wire logic                  serial_in_neg,
  input  wire logic                  sig_present,
  input  wire logic                  enable,
  output logic [15:0]                rx_data,
  output logic                       rx_data_oe_n,
  output logic                       rx_error_flag,
  output logic                       rx_error_oe_n,
  output logic                       rx_valid_or_sigloss,
  output logic                       rx_word_clk,
  output logic                       serial_out_pos,
  output logic                       serial_out_neg,
  output logic                       serial_out_oe_n
);
  import srd_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    srd_pins_t                  s1;
    srd_pins_t                  s2;
    logic                       lclk_d;
    logic [19:0]                sh;
    logic [4:0]                 cnt;
    logic                       aligned;
    logic                       align_en;
    srd_sync_t                  state;
    logic [1:0]                 run_cnt;
    logic [2:0]                 good_cnt;
    logic [1:0]                 bad_cnt;
    srd_word_t [LAT_WORDS-1:0]  pipe;
    srd_word_t                  out;
    logic                       valid_pin;
    logic                       oe_n;
    logic                       word_clk;
    logic                       wr_pend;
    logic [31:0]                wr_addr;
    logic [31:0]                rdata;
    logic                       hold;
    logic [15:0]                errcnt;
  } srd_state_t;

  srd_state_t q;
  srd_state_t n;
  logic       bit_edge;
  logic       live;
  logic       push;
  logic       fsm_go;
  logic       comma;
  logic       wr_clr;
  logic       rd_ph;
  logic [19:0] sh_new;
  logic [9:0]  dlo;
  logic [9:0]  dhi;
  srd_cls_t   cls;
  srd_word_t  wd;

  // ************************************************************
  // Decoding functions
  // ************************************************************
  // 6b to 5b, abcdei with a as MSB; result {ok, EDCBA}
  function automatic logic [5:0] dec6(input logic [5:0] c);
    logic [5:0] r;
    r = 6'h00;
    case (c)
      6'h27, 6'h18: r = 6'h20;
      6'h1D, 6'h22: r = 6'h21;
      6'h2D, 6'h12: r = 6'h22;
      6'h31:        r = 6'h23;
      6'h35, 6'h0A: r = 6'h24;
      6'h29:        r = 6'h25;
      6'h19:        r = 6'h26;
      6'h38, 6'h07: r = 6'h27;
      6'h39, 6'h06: r = 6'h28;
      6'h25:        r = 6'h29;
      6'h15:        r = 6'h2A;
      6'h34:        r = 6'h2B;
      6'h0D:        r = 6'h2C;
      6'h2C:        r = 6'h2D;
      6'h1C:        r = 6'h2E;
      6'h17, 6'h28: r = 6'h2F;
      6'h1B, 6'h24: r = 6'h30;
      6'h23:        r = 6'h31;
      6'h13:        r = 6'h32;
      6'h32:        r = 6'h33;
      6'h0B:        r = 6'h34;
      6'h2A:        r = 6'h35;
      6'h1A:        r = 6'h36;
      6'h3A, 6'h05: r = 6'h37;
      6'h33, 6'h0C: r = 6'h38;
      6'h26:        r = 6'h39;
      6'h16:        r = 6'h3A;
      6'h36, 6'h09: r = 6'h3B;
      6'h0E, 6'h0F, 6'h30: r = 6'h3C;
      6'h2E, 6'h11: r = 6'h3D;
      6'h1E, 6'h21: r = 6'h3E;
      6'h2B, 6'h14: r = 6'h3F;
      default:      r = 6'h00;
    endcase
    return r;
  endfunction

  // 4b to 3b, fghj with f as MSB; result {ok, HGF}
  function automatic logic [3:0] dec4(input logic [3:0] c);
    logic [3:0] r;
    r = 4'h0;
    case (c)
      4'hB, 4'h4:             r = 4'h8;
      4'h9:                   r = 4'h9;
      4'h5:                   r = 4'hA;
      4'hC, 4'h3:             r = 4'hB;
      4'hD, 4'h2:             r = 4'hC;
      4'hA:                   r = 4'hD;
      4'h6:                   r = 4'hE;
      4'hE, 4'h1, 4'h7, 4'h8: r = 4'hF;
      default:                r = 4'h0;
    endcase
    return r;
  endfunction

  // One 10-bit character, first bit in ch[0]; result {ok, k, byte}
  function automatic logic [9:0] dec10(input logic [9:0] ch);
    logic [5:0] six;
    logic [3:0] four;
    logic [5:0] r6;
    logic [3:0] r4;
    logic       kx7;
    six  = {ch[0], ch[1], ch[2], ch[3], ch[4], ch[5]};
    four = {ch[6], ch[7], ch[8], ch[9]};
    r6   = dec6(six);
    // Positive-disparity K28 sends its 4b group inverted
    r4   = dec4((six == SRD_K28_POS) ? ~four : four);
    kx7  = (four == 4'h7 || four == 4'h8) &&
           (r6[4:0] inside {5'h17, 5'h1B, 5'h1D, 5'h1E});
    return {r6[5] & r4[3], (six == SRD_K28_NEG) || (six == SRD_K28_POS) || kx7,
            r4[2:0], r6[4:0]};
  endfunction

  // Comma sits in the first seven bits of a character
  function automatic logic is_comma(input logic [9:0] ch);
    logic [6:0] s;
    s = {ch[0], ch[1], ch[2], ch[3], ch[4], ch[5], ch[6]};
    return (s == SRD_COMMA_NEG) || (s == SRD_COMMA_POS);
  endfunction

  // Word class from both halves, low half received first
  function automatic srd_cls_t classify(input logic [19:0] w);
    logic [9:0] lo;
    logic [9:0] hi;
    lo = dec10(w[9:0]);
    hi = dec10(w[19:10]);
    if (!lo[9] || !hi[9])
      return CLS_BAD;
    if (lo[8] && lo[7:0] == SRD_K28_5 && !hi[8] &&
        (hi[7:0] == SRD_D5_6 || hi[7:0] == SRD_D16_2))
      return CLS_IDLE;
    if (lo[8] && hi[8] && lo[7:0] == SRD_K23_7 && hi[7:0] == SRD_K23_7)
      return CLS_CAREXT;
    if (lo[8] && hi[8] && lo[7:0] == SRD_K30_7 && hi[7:0] == SRD_K30_7)
      return CLS_ERRP;
    if (!lo[8] && !hi[8])
      return CLS_DATA;
    return CLS_BAD;
  endfunction

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    n        = q;
    bit_edge = q.s2.lclk && !q.lclk_d;
    live     = q.s2.en && q.s2.sig;
    sh_new   = {q.s2.dp && !q.s2.dn, q.sh[19:1]};
    comma    = is_comma(sh_new[19:10]);
    cls      = classify(sh_new);
    dlo      = dec10(sh_new[9:0]);
    dhi      = dec10(sh_new[19:10]);
    push     = 1'b0;
    wr_clr   = 1'b0;
    rd_ph    = 1'b0;
    wd       = '0;

    // Pins pass two flops; link clock edges found by sampling
    n.s1     = {link_bit_clk, serial_in_pos, serial_in_neg, sig_present, enable};
    n.s2     = q.s1;
    n.lclk_d = q.s2.lclk;

    // Bit taken on each link clock rise, no recovery loop of our own
    if (bit_edge) begin
      n.sh = sh_new;
      if (q.align_en && comma) begin
        n.cnt     = SRD_HALF_BIT;
        n.aligned = 1'b1;
      end else if (q.cnt == SRD_LAST_BIT) begin
        n.cnt = 5'h00;
        push  = 1'b1;
      end else begin
        n.cnt = q.cnt + 5'h01;
      end
      // Aligned comma once linked freezes the boundary
      if (comma && q.cnt == SRD_HALF_BIT - 5'h01 && q.state != ACQUIRE_STATE)
        n.align_en = 1'b0;
    end

    // Status word per class
    unique case (cls)
      CLS_IDLE:   wd = '{1'b0, 1'b0, sh_new[19:0] == '0 ? 16'h0000 : 16'h0000};
      CLS_CAREXT: wd = '{1'b0, 1'b1, 16'h0000};
      CLS_DATA:   wd = '{1'b1, 1'b0, 16'h0000};
      CLS_ERRP:   wd = '{1'b1, 1'b1, SRD_ERRP_WORD};
      CLS_BAD:    wd = '{1'b1, 1'b1, 16'h0000};
    endcase
    if (cls != CLS_ERRP)
      wd.data = {dhi[7:0], dlo[7:0]};
    if (q.state == ACQUIRE_STATE && !q.aligned) begin
      wd.valid = 1'b0;
      wd.err   = 1'b0;
    end

    // Fixed-depth word delay sets the latency
    fsm_go = push && q.aligned && live && !q.hold;
    if (push) begin
      n.pipe[0] = wd;
      for (int i = 1; i < LAT_WORDS; i++)
        n.pipe[i] = q.pipe[i-1];
      n.out = q.pipe[LAT_WORDS-1];
    end

    // Sync machine
    if (!live || q.hold) begin
      n.state    = ACQUIRE_STATE;
      n.aligned  = 1'b0;
      n.align_en = 1'b1;
      n.run_cnt  = 2'h0;
    end else if (fsm_go) begin
      unique case (q.state)
        ACQUIRE_STATE: begin
          if (cls == CLS_IDLE || cls == CLS_CAREXT) begin
            n.run_cnt = q.run_cnt + 2'h1;
            if (q.run_cnt == SRD_IDLE_RUN - 2'h1) begin
              n.state   = SYNC_STATE;
              n.run_cnt = 2'h0;
            end
          end else if (cls == CLS_DATA || cls == CLS_ERRP) begin
            n.state   = SYNC_STATE;
            n.run_cnt = 2'h0;
          end else begin
            n.run_cnt = 2'h0;
          end
        end
        SYNC_STATE: begin
          if (cls == CLS_BAD) begin
            n.state    = CHECK_STATE;
            n.good_cnt = 3'h0;
            n.bad_cnt  = 2'h0;
          end
        end
        CHECK_STATE: begin
          if (cls == CLS_BAD) begin
            n.good_cnt = 3'h0;
            n.bad_cnt  = q.bad_cnt + 2'h1;
            if (q.bad_cnt == SRD_BAD_RUN - 2'h1) begin
              n.state    = ACQUIRE_STATE;
              n.aligned  = 1'b0;
              n.align_en = 1'b1;
            end
          end else begin
            n.good_cnt = q.good_cnt + 3'h1;
            if (q.good_cnt == SRD_GOOD_RUN - 3'h1)
              n.state = SYNC_STATE;
          end
        end
        default: n.state = ACQUIRE_STATE;
      endcase
    end

    // Pin drive: signal loss wins over data, power-down over both
    if (!q.s2.sig)
      n.out = '1;
    n.oe_n      = !q.s2.en;
    n.valid_pin = q.s2.en ? n.out.valid : q.s2.sig;
    n.word_clk  = q.cnt >= SRD_HALF_BIT;

    // AHB-Lite slave, zero wait, read data from next-state values
    n.wr_pend = 1'b0;
    if (ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1]) begin
      n.wr_pend = ahb_req.hwrite;
      n.wr_addr = ahb_req.haddr;
      rd_ph     = !ahb_req.hwrite;
    end
    if (q.wr_pend && q.wr_addr == SRD_CTRL_ADDR)
      n.hold = ahb_req.hwdata[SRD_CTRL_HOLD_BIT];
    wr_clr = q.wr_pend && q.wr_addr == SRD_ERRC_ADDR;
    // A clear in the same cycle as an invalid word leaves a count of one
    n.errcnt = wr_clr ? 16'h0000 : q.errcnt;
    if (fsm_go && cls == CLS_BAD)
      n.errcnt = n.errcnt + 16'h0001;
    if (rd_ph) begin
      n.rdata = 32'h0000_0000;
      if (ahb_req.haddr == SRD_CTRL_ADDR)
        n.rdata[SRD_CTRL_HOLD_BIT] = n.hold;
      if (ahb_req.haddr == SRD_STAT_ADDR) begin
        n.rdata[SRD_STAT_STATE_LSB +: 2] = n.state;
        n.rdata[SRD_STAT_ALIGN_BIT]      = n.aligned;
        n.rdata[SRD_STAT_REAL_BIT]       = n.align_en;
        n.rdata[SRD_STAT_SIG_BIT]        = n.s2.sig;
        n.rdata[SRD_STAT_EN_BIT]         = n.s2.en;
      end
      if (ahb_req.haddr == SRD_ERRC_ADDR)
        n.rdata[15:0] = n.errcnt;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Reset: acquisition, realign on, pins high-impedance
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q          <= '0;
      q.align_en <= 1'b1;
      q.oe_n     <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Outputs; transmit path is absent, its pins drive low or tri-state
  assign rx_data             = q.out.data;
  assign rx_data_oe_n        = q.oe_n;
  assign rx_error_flag       = q.out.err;
  assign rx_error_oe_n       = q.oe_n;
  assign rx_valid_or_sigloss = q.valid_pin;
  assign rx_word_clk         = q.word_clk;
  assign serial_out_pos      = 1'b0;
  assign serial_out_neg      = 1'b0;
  assign serial_out_oe_n     = q.oe_n;
  assign ahb_rsp             = '{1'b1, 1'b0, q.rdata};

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);

  idle_sync_a:
    assert property (fsm_go && q.state == ACQUIRE_STATE && q.run_cnt == 2'h2 &&
                     (cls == CLS_IDLE || cls == CLS_CAREXT) |=> q.state == SYNC_STATE)
    else $error("idle run did not enter sync");
  data_sync_a:
    assert property (fsm_go && q.state == ACQUIRE_STATE &&
                     (cls == CLS_DATA || cls == CLS_ERRP) |=> q.state == SYNC_STATE)
    else $error("data in acquisition did not enter sync");
  bad_check_a:
    assert property (fsm_go && q.state == SYNC_STATE && cls == CLS_BAD
                     |=> q.state == CHECK_STATE && q.pipe[0].valid && q.pipe[0].err)
    else $error("invalid code in sync not handled");
  check_good_a:
    assert property (fsm_go && q.state == CHECK_STATE && cls != CLS_BAD &&
                     q.good_cnt == 3'h3 |=> q.state == SYNC_STATE)
    else $error("four good codes did not restore sync");
  check_loss_a:
    assert property (fsm_go && q.state == CHECK_STATE && cls == CLS_BAD &&
                     q.bad_cnt == 2'h2 |=> q.state == ACQUIRE_STATE && q.align_en)
    else $error("third invalid code did not drop the link");
  realign_acq_a:
    assert property ($rose(q.align_en) |-> q.state == ACQUIRE_STATE)
    else $error("realignment enabled outside acquisition");
  errp_word_a:
    assert property (push && q.aligned && cls == CLS_ERRP
                     |=> q.pipe[0] == {2'b11, SRD_ERRP_WORD})
    else $error("error propagation word wrong");
  idle_word_a:
    assert property (push && q.aligned && cls == CLS_IDLE |=> !q.pipe[0].valid &&
                     !q.pipe[0].err && q.pipe[0].data[7:0] == SRD_K28_5)
    else $error("idle word wrong");
  lat_fixed_a:
    assert property (push && q.s2.sig |=> q.out == $past(q.pipe[LAT_WORDS-1]))
    else $error("word delay not fixed");
  los_ones_a:
    assert property (!q.s2.sig && q.s2.en |=> rx_data == 16'hFFFF && rx_error_flag &&
                     rx_valid_or_sigloss)
    else $error("signal loss not shown");
  pdown_pins_a:
    assert property (!q.s2.en |=> rx_data_oe_n && rx_error_oe_n && serial_out_oe_n &&
                     rx_valid_or_sigloss == $past(q.s2.sig))
    else $error("power-down pins wrong");

  sync_reached_c: cover property (q.state == ACQUIRE_STATE ##1 q.state == SYNC_STATE);
  check_back_c: cover property (q.state == CHECK_STATE ##1 q.state == SYNC_STATE);
  link_lost_c: cover property (q.state == CHECK_STATE ##1 q.state == ACQUIRE_STATE);
  sig_lost_c: cover property (q.s2.en && !q.s2.sig);
endmodule
`default_nettype wire

// [common/srd_pkg.sv]
// Constants and types shared by the serial receive decoder
package srd_pkg;
  // ************************************************************
  // Register map (AHB-Lite, one word per register)
  // ************************************************************
  localparam logic [31:0] SRD_CTRL_ADDR      = 32'h0000_0000;
  localparam logic [31:0] SRD_STAT_ADDR      = 32'h0000_0004;
  localparam logic [31:0] SRD_ERRC_ADDR      = 32'h0000_0008;
  localparam int          SRD_CTRL_HOLD_BIT  = 0;
  localparam logic        SRD_CTRL_HOLD_RST  = 1'b0;
  localparam int          SRD_STAT_STATE_LSB = 0;
  localparam int          SRD_STAT_ALIGN_BIT = 2;
  localparam int          SRD_STAT_REAL_BIT  = 3;
  localparam int          SRD_STAT_SIG_BIT   = 4;
  localparam int          SRD_STAT_EN_BIT    = 5;

  // ************************************************************
  // Framing and code points
  // ************************************************************
  localparam logic [4:0]  SRD_LAST_BIT   = 5'h13;
  localparam logic [4:0]  SRD_HALF_BIT   = 5'h0A;
  localparam logic [6:0]  SRD_COMMA_NEG  = 7'h1F;
  localparam logic [6:0]  SRD_COMMA_POS  = 7'h60;
  localparam logic [5:0]  SRD_K28_NEG    = 6'h0F;
  localparam logic [5:0]  SRD_K28_POS    = 6'h30;
  localparam logic [7:0]  SRD_K28_5      = 8'hBC;
  localparam logic [7:0]  SRD_D5_6       = 8'hC5;
  localparam logic [7:0]  SRD_D16_2      = 8'h50;
  localparam logic [7:0]  SRD_K23_7      = 8'hF7;
  localparam logic [7:0]  SRD_K30_7      = 8'hFE;
  localparam logic [15:0] SRD_ERRP_WORD  = 16'hFEFE;

  // ************************************************************
  // Sync machine counts and latency
  // ************************************************************
  localparam logic [1:0]  SRD_IDLE_RUN   = 2'h3;
  localparam logic [2:0]  SRD_GOOD_RUN   = 3'h4;
  localparam logic [1:0]  SRD_BAD_RUN    = 2'h3;
  localparam int          SRD_LAT_WORDS  = 3;
  localparam int          SRD_LAT_MIN    = 76;
  localparam int          SRD_LAT_MAX    = 107;

  typedef enum logic [1:0] {
    ACQUIRE_STATE = 2'b00,
    SYNC_STATE    = 2'b01,
    CHECK_STATE   = 2'b10
  } srd_sync_t;

  typedef enum logic [2:0] {
    CLS_IDLE   = 3'b000,
    CLS_CAREXT = 3'b001,
    CLS_DATA   = 3'b010,
    CLS_ERRP   = 3'b011,
    CLS_BAD    = 3'b100
  } srd_cls_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [15:0] data;
  } srd_word_t;

  typedef struct packed {
    logic lclk;
    logic dp;
    logic dn;
    logic sig;
    logic en;
  } srd_pins_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } srd_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } srd_ahb_rsp_t;
endpackage

// [dv/srd_far_tx.sv]
// Far-end serial transmitter model for the receive decoder bench
`timescale 1ns/1ps
`default_nettype none
module srd_far_tx (
  output var  logic lclk,
  output var  logic dp,
  output var  logic dn,
  output wire logic sig,
  input  wire logic cut
);
  logic [19:0] q[$];
  logic [19:0] w;
  logic        b;

  // Detector level simply follows the cable
  assign sig = ~cut;

  // Word stream; the idle pair fills any gap, bit time matches the local rate
  initial begin
    lclk = 1'b0;
    b = 1'b0;
    dp = 1'b0;
    dn = 1'b1;
    forever begin
      w = (q.size() > 0) ? q.pop_front() : 20'hA58FA;
      for (int i = 0; i < 20; i++) begin
        // A cut cable stops the clock; lines toggle so no stale bit survives
        if (cut) begin
          b = ~b;
          dp = b;
          dn = ~b;
          #160;
        end else begin
          b = w[(i < 10) ? 9 - i : 29 - i];
          dp = b;
          dn = ~b;
          #80 lclk = 1'b1;
          #80 lclk = 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [dv/serdes_receive_decode_sync_tb_top.sv]
// Self-checking bench for the serial receive decoder
`timescale 1ns/1ps
`default_nettype none
module serdes_receive_decode_sync_tb_top;
  import srd_pkg::*;
  localparam logic [9:0] K285 = 10'h0FA;
  localparam logic [9:0] D56  = 10'h296;
  localparam logic [9:0] D162 = 10'h1B5;
  localparam logic [9:0] DC[4] = '{10'h274, 10'h2AA, 10'h155, 10'h296};
  localparam logic [7:0] DB[4] = '{8'h00, 8'hB5, 8'h4A, 8'hC5};
  logic         hclk, hresetn, enable, cut, lclk, dp, dn, sig, prev, chk_on;
  logic         rx_err, rx_val, wclk, doe, eoe, soe;
  logic [15:0]  rx_data;
  logic [31:0]  rd;
  logic [17:0]  xo;
  logic [18:0]  ex;
  logic [18:0]  exq[$];
  srd_ahb_req_t req;
  srd_ahb_rsp_t rsp;
  int           bad_count, checks, cyc, pend, m_st, m_run, m_good, m_bad, m_err;

  // Free-running system clock
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;
  srd_far_tx u_far (.lclk(lclk), .dp(dp), .dn(dn), .sig(sig), .cut(cut));
  // Single slave, so its ready is the bus ready; wired here to avoid a time-zero race
  srd_rx_top u_dut (.hclk(hclk), .hresetn(hresetn), .ahb_rsp(rsp),
    .ahb_req('{req.hsel, req.haddr, req.htrans, req.hwrite, req.hsize, rsp.hreadyout,
               req.hwdata}),
    .link_bit_clk(lclk), .serial_in_pos(dp), .serial_in_neg(dn), .sig_present(sig),
    .enable(enable), .rx_data(rx_data), .rx_data_oe_n(doe), .rx_error_flag(rx_err),
    .rx_error_oe_n(eoe), .rx_valid_or_sigloss(rx_val), .rx_word_clk(wclk),
    .serial_out_pos(), .serial_out_neg(), .serial_out_oe_n(soe));

  task automatic conclude();
    $display("Checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // One AHB single transfer; address held until ready, data after it
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    req.hsel <= 1'b1;
    req.htrans <= 2'b10;
    req.haddr <= a;
    req.hwrite <= w;
    req.hsize <= 3'b010;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    req.hsel <= 1'b0;
    req.htrans <= 2'b00;
    req.hwdata <= d;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask

  // Link state model: classes 0 idle, 1 extend, 2 data, 3 errprop, 4 invalid
  task automatic step(input int c);
    if (c == 4) m_err++;
    case (m_st)
      0: if (c == 4) m_run = 0; else if (c > 1 || ++m_run == 3) m_st = 1;
      1: if (c == 4) begin m_st = 2; m_good = 0; m_bad = 0; end
      default: if (c != 4) begin if (++m_good == 4) m_st = 1; end
        else begin m_good = 0; if (++m_bad == 3) begin m_st = 0; m_run = 0; end end
    endcase
  endtask

  // Queue one word at the far end and, unless idle, its expected result here
  task automatic send(input int c, input logic cr);
    logic [9:0] lo, hi;
    int i, j;
    i = $urandom % 4;
    j = $urandom % 4;
    case (c)
      0: begin lo = K285; hi = i[0] ? D162 : D56; end
      1: begin lo = 10'h3A8; hi = lo; ex = {3'b101, 16'hF7F7}; end
      2: begin lo = DC[i]; hi = DC[j]; ex = {3'b110, DB[j], DB[i]}; end
      3: begin lo = 10'h1E8; hi = lo; ex = {3'b111, SRD_ERRP_WORD}; end
      default: begin lo = 10'h000; hi = lo; ex = {2'b01, cr, 16'h0000}; end
    endcase
    ex[18] = cr;
    u_far.q.push_back({hi, lo});
    if (c != 0) exq.push_back(ex);
    step(c);
    pend++;
  endtask

  task automatic drain();
    repeat ((pend + 6) * 320) @(posedge hclk);
    pend = 0;
  endtask

  task automatic stat();
    bus(1'b0, SRD_STAT_ADDR, 32'h0);
    chk(rd[1:0], m_st[1:0]);
  endtask

  // Word monitor and cycle ceiling
  always @(posedge hclk) begin
    prev <= wclk;
    cyc <= cyc + 1;
    if (cyc > 80000) begin
      bad_count++;
      conclude();
    end
    if (chk_on && wclk === 1'b1 && prev === 1'b0) begin
      xo = {rx_val, rx_err, rx_data};
      if (xo[17:16] === 2'b00 && (xo[15:0] === 16'hC5BC || xo[15:0] === 16'h50BC))
        checks++;
      else if (exq.size() == 0) chk(xo, 32'h0);
      else begin
        ex = exq.pop_front();
        if (ex[18]) chk(xo[17:16], ex[17:16]);
        if (ex[18] && (ex[15:0] != 0 || ex[17:16] != 2'b11)) chk(xo[15:0], ex[15:0]);
      end
    end
  end

  // Main sequence
  initial begin
    hresetn = 1'b0;
    enable = 1'b1;
    cut = 1'b0;
    req = '0;
    chk_on = 1'b0;
    {bad_count, checks, cyc, pend, m_st, m_run, m_good, m_bad, m_err} = '0;
    void'($urandom(11764));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, SRD_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 32'h0000_000C, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, SRD_STAT_ADDR, 32'h0);
    chk(rd[3:0], 4'b1000);
    repeat (6) send(0, 1'b1);
    drain();
    stat();
    chk(rd[3:2], 2'b01);
    chk_on = 1'b1;
    for (int n = 0; n < 12; n++) send((n % 6 == 5) ? 1 : (n % 6 == 4) ? 3 : 2, 1'b1);
    send(4, 1'b1);
    repeat (4) send(2, 1'b1);
    repeat (2) send(4, 1'b1);
    repeat (4) send(2, 1'b1);
    drain();
    stat();
    bus(1'b0, SRD_ERRC_ADDR, 32'h0);
    chk(rd, m_err);
    bus(1'b1, SRD_ERRC_ADDR, 32'h1);
    bus(1'b0, SRD_ERRC_ADDR, 32'h0);
    chk(rd, 32'h0);
    repeat (14) send(4, 1'b0);
    repeat (10 * 320) @(posedge hclk);
    stat();
    chk(rd[3], 1'b1);
    repeat (6) send(0, 1'b1);
    drain();
    stat();
    chk_on = 1'b0;
    bus(1'b1, SRD_CTRL_ADDR, 32'h1);
    bus(1'b0, SRD_CTRL_ADDR, 32'h0);
    chk(rd, 32'h1);
    {m_st, m_run} = '0;
    repeat (640) @(posedge hclk);
    stat();
    bus(1'b1, SRD_CTRL_ADDR, 32'h0);
    cut <= 1'b1;
    repeat (6) @(posedge hclk);
    chk({rx_val, rx_err, rx_data}, 18'h3FFFF);
    cut <= 1'b0;
    repeat (6) send(0, 1'b1);
    drain();
    stat();
    enable <= 1'b0;
    repeat (6) @(posedge hclk);
    chk({doe, eoe, soe, rx_val}, 4'b1111);
    bus(1'b0, SRD_STAT_ADDR, 32'h0);
    chk(rd[5:4], 2'b01);
    cut <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(rx_val, 1'b0);
    cut <= 1'b0;
    enable <= 1'b1;
    {m_st, m_run} = '0;
    repeat (6) send(0, 1'b1);
    drain();
    stat();
    chk_on = 1'b1;
    repeat (4) send(2, 1'b1);
    drain();
    chk(exq.size(), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
